// ===== core/rfs_core.sv
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rfs_params.svh"

// How it works
// - Count register reports characters held, tracking every write and host read.
// - In 64-byte mode the count uses bits 6:0 only, 64 reads 0x40.
// - In 256-byte mode count is nine bits, MSB in interrupt source bit 6.
// - Flow status bits 7:6 and 3:2 always read zero.
// - Receive hardware throttle bit reads zero unless FIFO and auto-RTS enabled.
// - Fill above upper sets bit 5 and RTS not-ready; at most lower clears it.
// - Arrivals still stored while throttled if space remains; dropped once full.
// - Receive software throttle bit reads zero unless FIFO and software control enabled.
// - Fill above upper sets bit 4 and sends Xoff.
// - After Xoff, fill down to lower clears bit 4 and sends Xon.
// - Transmit hardware throttle bit reads zero unless FIFO and auto-CTS enabled.
// - Bit 1 mirrors CTS; high holds transmit data, low lets it go.
// - Received Xoff sets bit 0 and halts transmit; later Xon clears it.
module rfs_core (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic cts_n,
  output logic rts_n,
  output logic tx_halt,
  output logic send_xon,
  output logic send_xoff,
  output logic irq
);

  localparam rfs_pkg::rfs_state_t ST_RST = '{
    ctrl: `RFS_CTRL_RST,
    upper: `RFS_UPPER_RST,
    lower: `RFS_LOWER_RST,
    xon: `RFS_XON_RST,
    xoff: `RFS_XOFF_RST,
    irq_st: `RFS_IRQ_RST,
    irq_msk: `RFS_IRQ_RST,
    ready: 1'b1,
    default: '0
  };

  rfs_pkg::rfs_state_t q, d;

  // ==========================================
  // Receive FIFO
  logic [8:0] cnt;
  logic [8:0] cap;
  logic [7:0] fifo_rd;
  logic fifo_wr;
  logic fifo_ready;
  logic fifo_pop;
  logic take;
  logic fifo_en;
  logic hw_en;
  logic sw_tx_en;
  logic sw_rx_en;
  logic cts_en;
  logic is_xoff;
  logic is_xon;
  logic drop;

  function automatic logic thr_next(
    input logic cur,
    input logic en,
    input logic [8:0] c,
    input logic [8:0] up,
    input logic [8:0] lo
  );
    // Hysteresis: set above upper, release at or below lower or when disabled
    if (!en) begin
      thr_next = 1'b0;
    end else if (c > up) begin
      thr_next = 1'b1;
    end else if (c <= lo) begin
      thr_next = 1'b0;
    end else begin
      thr_next = cur;
    end
  endfunction : thr_next

  assign take = hsel && htrans[1] && hready;
  assign fifo_en = q.ctrl[`RFS_CTRL_FIFO_EN];
  assign hw_en = fifo_en && q.ctrl[`RFS_CTRL_AUTO_RTS];
  assign sw_tx_en = fifo_en && q.ctrl[`RFS_CTRL_SW_TX];
  assign sw_rx_en = fifo_en && q.ctrl[`RFS_CTRL_SW_RX];
  assign cts_en = fifo_en && q.ctrl[`RFS_CTRL_AUTO_CTS];
  assign is_xoff = rx_valid && sw_rx_en && (rx_data == q.xoff);
  assign is_xon = rx_valid && sw_rx_en && (rx_data == q.xon) && !is_xoff;
  // Flow characters are consumed, never stored, while software receive control is on
  assign fifo_wr = rx_valid && !is_xoff && !is_xon;
  assign drop = fifo_wr && !fifo_ready;
  assign fifo_pop = take && !hwrite && (haddr[7:0] == `RFS_OFF_RXDATA);
  // With the FIFO off a single holding slot remains
  assign cap = !fifo_en ? 9'h001 :
               q.ctrl[`RFS_CTRL_MODE256] ? 9'h100 : 9'h040;

  rfs_rx_fifo #(
    .DEPTH(`RFS_DEPTH_BIG)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .flush(q.flush),
    .cap(cap),
    .wr_valid(fifo_wr),
    .wr_data(rx_data),
    .wr_ready(fifo_ready),
    .rd_en(fifo_pop),
    .rd_data(fifo_rd),
    .count(cnt)
  );

  // ==========================================
  // State update
  always_comb begin
    logic [31:0] rv;
    logic [2:0] ev;
    logic [2:0] clr;
    rv = '0;
    ev = '0;
    clr = '0;
    d = q;
    d.send_xon = 1'b0;
    d.send_xoff = 1'b0;
    d.flush = 1'b0;
    d.ready = 1'b1;
    d.cts_m = cts_n;
    d.cts_s = q.cts_m;

    // Read data is formed in the address phase and stands in the data phase
    unique case (haddr[7:0])
      `RFS_OFF_CTRL: rv[5:0] = q.ctrl;
      `RFS_OFF_UPPER: rv[8:0] = q.upper;
      `RFS_OFF_LOWER: rv[8:0] = q.lower;
      `RFS_OFF_XON: rv[7:0] = q.xon;
      `RFS_OFF_XOFF: rv[7:0] = q.xoff;
      `RFS_OFF_RXDATA: begin
        rv[7:0] = fifo_rd;
        rv[`RFS_RXDATA_VALID] = cnt != 9'h000;
      end
      `RFS_OFF_COUNT: begin
        if (q.ctrl[`RFS_CTRL_MODE256]) begin
          rv[7:0] = cnt[7:0];
        end else begin
          rv[6:0] = cnt[6:0];
        end
      end
      `RFS_OFF_FSR: begin
        rv[`RFS_FSR_RX_HW] = q.rx_hw;
        rv[`RFS_FSR_RX_SW] = q.rx_sw;
        rv[`RFS_FSR_TX_HW] = q.tx_hw;
        rv[`RFS_FSR_TX_SW] = q.tx_sw;
      end
      `RFS_OFF_ISR: rv[`RFS_ISR_CNT_MSB] = q.ctrl[`RFS_CTRL_MODE256] && cnt[8];
      `RFS_OFF_IRQ_ST: rv[2:0] = q.irq_st;
      `RFS_OFF_IRQ_MSK: rv[2:0] = q.irq_msk;
      default: rv = '0;
    endcase

    d.ap_v = take;
    if (take) begin
      d.ap_wr = hwrite;
      d.ap_off = haddr[7:0];
      if (!hwrite) begin
        d.rdata = rv;
      end
    end

    // Count, flow status and interrupt source have no write case
    if (q.ap_v && q.ap_wr) begin
      unique case (q.ap_off)
        `RFS_OFF_CTRL: begin
          d.ctrl = hwdata[5:0];
          // Resize or disable empties the FIFO, no stale fill survives
          d.flush = (hwdata[`RFS_CTRL_FIFO_EN] != q.ctrl[`RFS_CTRL_FIFO_EN]) ||
                    (hwdata[`RFS_CTRL_MODE256] != q.ctrl[`RFS_CTRL_MODE256]);
        end
        `RFS_OFF_UPPER: d.upper = hwdata[8:0];
        `RFS_OFF_LOWER: d.lower = hwdata[8:0];
        `RFS_OFF_XON: d.xon = hwdata[7:0];
        `RFS_OFF_XOFF: d.xoff = hwdata[7:0];
        `RFS_OFF_IRQ_ST: clr = hwdata[2:0];
        `RFS_OFF_IRQ_MSK: d.irq_msk = hwdata[2:0];
        default: clr = '0;
      endcase
    end

    // Receive throttling
    d.rx_hw = thr_next(q.rx_hw, hw_en, cnt, q.upper, q.lower);
    d.rx_sw = thr_next(q.rx_sw, sw_tx_en, cnt, q.upper, q.lower);
    d.send_xoff = !q.rx_sw && d.rx_sw;
    // Disabling software control drops the state without sending Xon
    d.send_xon = q.rx_sw && !d.rx_sw && sw_tx_en;

    // Transmit throttling
    d.tx_hw = cts_en && q.cts_s;
    if (!sw_rx_en) begin
      d.tx_sw = 1'b0;
    end else if (is_xoff) begin
      d.tx_sw = 1'b1;
    end else if (is_xon) begin
      d.tx_sw = 1'b0;
    end
    d.tx_halt = d.tx_hw || d.tx_sw;

    // Sticky events; a new event outranks a same-cycle clear
    ev[`RFS_IRQ_THROTTLE] = (!q.rx_hw && d.rx_hw) || (!q.rx_sw && d.rx_sw);
    ev[`RFS_IRQ_XOFF] = is_xoff;
    ev[`RFS_IRQ_DROP] = drop;
    d.irq_st = (q.irq_st & ~clr) | ev;
    d.irq = |(d.irq_st & d.irq_msk);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs
  assign hreadyout = q.ready;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign rts_n = q.rx_hw;
  assign tx_halt = q.tx_halt;
  assign send_xon = q.send_xon;
  assign send_xoff = q.send_xoff;
  assign irq = q.irq;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence s_cts_high;
    (cts_en && cts_n) [*3];
  endsequence

  sequence s_release;
    q.rx_sw && sw_tx_en && (cnt <= q.lower) && (cnt <= q.upper);
  endsequence

  AST_FSR_UNUSED_ZERO: assert property (
    take && !hwrite && haddr[7:0] == `RFS_OFF_FSR
    |=> hrdata[7:6] == 2'b00 && hrdata[3:2] == 2'b00)
    else $error("Unused flow status bits not zero");

  AST_COUNT64_WIDTH: assert property (
    take && !hwrite && haddr[7:0] == `RFS_OFF_COUNT && !q.ctrl[`RFS_CTRL_MODE256]
    |=> hrdata[7:0] == {1'b0, $past(cnt[6:0])})
    else $error("64-byte count read wrong");

  AST_ISR_MSB: assert property (
    take && !hwrite && haddr[7:0] == `RFS_OFF_ISR && q.ctrl[`RFS_CTRL_MODE256]
    |=> hrdata[`RFS_ISR_CNT_MSB] == $past(cnt[8]))
    else $error("Count MSB not in interrupt source bit");

  AST_RX_HW_OFF: assert property (
    !hw_en |=> !q.rx_hw && !rts_n)
    else $error("Receive hardware throttle set while disabled");

  AST_RX_HW_SET: assert property (
    hw_en && cnt > q.upper |=> q.rx_hw && rts_n)
    else $error("Receive hardware throttle missed upper threshold");

  AST_RX_HW_HOLD: assert property (
    q.rx_hw && hw_en && cnt > q.lower |=> q.rx_hw)
    else $error("Receive hardware throttle released above lower");

  AST_RX_SW_OFF: assert property (
    !sw_tx_en |=> !q.rx_sw)
    else $error("Receive software throttle set while disabled");

  AST_XOFF_SEND: assert property (
    sw_tx_en && !q.rx_sw && cnt > q.upper |=> q.rx_sw && send_xoff ##1 !send_xoff)
    else $error("Xoff not sent once on upper threshold");

  AST_XON_SEND: assert property (
    s_release |=> !q.rx_sw && send_xon)
    else $error("Xon not sent on lower threshold");

  AST_CTS_OFF: assert property (
    !cts_en |=> !q.tx_hw)
    else $error("Transmit hardware throttle set while disabled");

  AST_CTS_MIRROR: assert property (
    s_cts_high |=> q.tx_hw && tx_halt)
    else $error("CTS high did not halt transmit");

  AST_XOFF_RX: assert property (
    is_xoff |=> q.tx_sw && tx_halt)
    else $error("Received Xoff did not halt transmit");

  AST_XON_RX: assert property (
    is_xon |=> !q.tx_sw && (tx_halt == q.tx_hw))
    else $error("Received Xon did not resume transmit");

  AST_RO_STATUS: assert property (
    q.ap_v && q.ap_wr && q.ap_off inside {`RFS_OFF_COUNT, `RFS_OFF_FSR}
    |=> q.ctrl == $past(q.ctrl) && q.upper == $past(q.upper))
    else $error("Write to read-only register changed state");

endmodule : rfs_core

// ===== core/rfs_params.svh
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH

// ==========================================
// Register byte offsets
`define RFS_OFF_CTRL 8'h00
`define RFS_OFF_UPPER 8'h04
`define RFS_OFF_LOWER 8'h08
`define RFS_OFF_XON 8'h0c
`define RFS_OFF_XOFF 8'h10
`define RFS_OFF_RXDATA 8'h14
`define RFS_OFF_COUNT 8'h18
`define RFS_OFF_FSR 8'h1c
`define RFS_OFF_ISR 8'h20
`define RFS_OFF_IRQ_ST 8'h24
`define RFS_OFF_IRQ_MSK 8'h28

// ==========================================
// Control field positions
`define RFS_CTRL_FIFO_EN 0
`define RFS_CTRL_MODE256 1
`define RFS_CTRL_AUTO_RTS 2
`define RFS_CTRL_AUTO_CTS 3
`define RFS_CTRL_SW_TX 4
`define RFS_CTRL_SW_RX 5

// ==========================================
// Status field positions
`define RFS_FSR_RX_HW 5
`define RFS_FSR_RX_SW 4
`define RFS_FSR_TX_HW 1
`define RFS_FSR_TX_SW 0
`define RFS_ISR_CNT_MSB 6
`define RFS_RXDATA_VALID 8
`define RFS_IRQ_THROTTLE 0
`define RFS_IRQ_XOFF 1
`define RFS_IRQ_DROP 2

// ==========================================
// Reset values
`define RFS_CTRL_RST 6'h00
`define RFS_UPPER_RST 9'h030
`define RFS_LOWER_RST 9'h010
`define RFS_XON_RST 8'h11
`define RFS_XOFF_RST 8'h13
`define RFS_IRQ_RST 3'h0

// ==========================================
// FIFO capacities
`define RFS_DEPTH_BIG 256
`define RFS_DEPTH_SMALL 64

`endif

// ===== core/rfs_pkg.sv
package rfs_pkg;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [8:0] upper;
    logic [8:0] lower;
    logic [7:0] xon;
    logic [7:0] xoff;
    logic [2:0] irq_st;
    logic [2:0] irq_msk;
    logic ap_v;
    logic ap_wr;
    logic [7:0] ap_off;
    logic [31:0] rdata;
    logic ready;
    logic cts_m;
    logic cts_s;
    logic rx_hw;
    logic rx_sw;
    logic tx_hw;
    logic tx_sw;
    logic tx_halt;
    logic send_xon;
    logic send_xoff;
    logic irq;
    logic flush;
  } rfs_state_t;

endpackage : rfs_pkg

// ===== core/rfs_rx_fifo.sv
`timescale 1ns/1ps
`include "rfs_params.svh"

module rfs_rx_fifo #(
  parameter int DEPTH = `RFS_DEPTH_BIG,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic [AW:0] cap,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic [AW:0] count
);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rfs_fifo_state_t;

  rfs_fifo_state_t q, d;
  logic [7:0] mem [DEPTH];
  logic push;
  logic pop;

  // Capacity shrinks in 64 mode or with the FIFO off; excess arrivals drop
  assign wr_ready = q.cnt < cap;
  assign push = wr_valid && wr_ready;
  assign pop = rd_en && (q.cnt != '0);
  assign rd_data = mem[q.rp];
  assign count = q.cnt;

  always_comb begin
    d = q;
    if (flush) begin
      d = '0;
    end else begin
      if (push) begin
        d.wp = q.wp + 1'b1;
      end
      if (pop) begin
        d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push && !flush) begin
      mem[q.wp] <= wr_data;
    end
  end

endmodule : rfs_rx_fifo

// ===== sim/rfs_remote.sv
`timescale 1ns/1ps
// ======
// Remote serial peer
module rfs_remote (
  input wire logic sys_clk,
  input wire logic rts_n,
  input wire logic send_xon,
  input wire logic send_xoff,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic cts_n
);
  int n_xon = 0;
  int n_xoff = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    cts_n = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (send_xon === 1'b1) n_xon++;
    if (send_xoff === 1'b1) n_xoff++;
  end
  // Ignores rts_n on purpose so the FIFO can be driven past full
  task send(input logic [7:0] c0, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= c0 + 8'(i);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
  task set_cts(input logic v);
    @(posedge sys_clk);
    cts_n <= v;
  endtask : set_cts
endmodule : rfs_remote

// ===== sim/rx_fill_count_flow_status_test.sv
`timescale 1ns/1ps
`include "rfs_params.svh"
module rx_fill_count_flow_status_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, rx_valid, cts_n, rts_n, tx_halt, send_xon, send_xoff, irq;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [7:0] rx_data;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  rfs_core uut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .cts_n(cts_n), .rts_n(rts_n), .tx_halt(tx_halt),
    .send_xon(send_xon), .send_xoff(send_xoff), .irq(irq));
  rfs_remote peer (.sys_clk(sys_clk), .rts_n(rts_n), .send_xon(send_xon),
    .send_xoff(send_xoff), .rx_valid(rx_valid), .rx_data(rx_data), .cts_n(cts_n));
  // ======
  // Checking and bus tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : bus
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rdc
  task pops(input int n);
    repeat (n) bus(1'b0, `RFS_OFF_RXDATA, 32'h0);
    repeat (2) @(posedge sys_clk);
  endtask : pops
  task stop_test;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Whole run needs about 1300 cycles; ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  // ======
  // Scenarios
  task t_reset;
    rdc(`RFS_OFF_CTRL, 32'h0);
    rdc(`RFS_OFF_UPPER, 32'h30);
    rdc(`RFS_OFF_XON, 32'h11);
    rdc(`RFS_OFF_XOFF, 32'h13);
    rdc(`RFS_OFF_COUNT, 32'h0);
    rdc(`RFS_OFF_FSR, 32'h0);
    rdc(8'h2c, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task t_hw;
    bus(1'b1, `RFS_OFF_UPPER, 32'h3);
    bus(1'b1, `RFS_OFF_LOWER, 32'h1);
    bus(1'b1, `RFS_OFF_CTRL, 32'h05);
    repeat (2) @(posedge sys_clk);
    peer.send(8'h40, 66);
    chk({31'h0, rts_n}, 32'h1);
    bus(1'b1, `RFS_OFF_COUNT, 32'hffffffff);
    bus(1'b1, `RFS_OFF_FSR, 32'hffffffff);
    rdc(`RFS_OFF_COUNT, 32'h40);
    rdc(`RFS_OFF_FSR, 32'h20);
    rdc(`RFS_OFF_IRQ_ST, 32'h5);
    bus(1'b1, `RFS_OFF_IRQ_MSK, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `RFS_OFF_IRQ_ST, 32'h7);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(`RFS_OFF_RXDATA, 32'h140);
    pops(61);
    rdc(`RFS_OFF_FSR, 32'h20);
    rdc(`RFS_OFF_RXDATA, 32'h17e);
    repeat (2) @(posedge sys_clk);
    rdc(`RFS_OFF_FSR, 32'h0);
    chk({31'h0, rts_n}, 32'h0);
    rdc(`RFS_OFF_COUNT, 32'h1);
    $display("t_hw done");
  endtask : t_hw
  task t_sw;
    bus(1'b1, `RFS_OFF_UPPER, 32'h80);
    bus(1'b1, `RFS_OFF_LOWER, 32'h10);
    bus(1'b1, `RFS_OFF_CTRL, 32'h13);
    repeat (2) @(posedge sys_clk);
    peer.send(8'h00, 256);
    rdc(`RFS_OFF_COUNT, 32'h0);
    rdc(`RFS_OFF_ISR, 32'h40);
    rdc(`RFS_OFF_FSR, 32'h10);
    chk(32'(peer.n_xoff), 32'h1);
    pops(239);
    rdc(`RFS_OFF_FSR, 32'h10);
    pops(1);
    rdc(`RFS_OFF_FSR, 32'h0);
    chk(32'(peer.n_xon), 32'h1);
    rdc(`RFS_OFF_COUNT, 32'h10);
    bus(1'b1, `RFS_OFF_CTRL, 32'h03);
    peer.send(8'h20, 200);
    rdc(`RFS_OFF_FSR, 32'h0);
    $display("t_sw done");
  endtask : t_sw
  task t_tx;
    bus(1'b1, `RFS_OFF_CTRL, 32'h29);
    peer.set_cts(1'b1);
    repeat (4) @(posedge sys_clk);
    rdc(`RFS_OFF_FSR, 32'h2);
    chk({31'h0, tx_halt}, 32'h1);
    peer.set_cts(1'b0);
    repeat (4) @(posedge sys_clk);
    rdc(`RFS_OFF_FSR, 32'h0);
    peer.send(8'h13, 1);
    repeat (2) @(posedge sys_clk);
    rdc(`RFS_OFF_FSR, 32'h1);
    chk({31'h0, tx_halt}, 32'h1);
    rdc(`RFS_OFF_COUNT, 32'h0);
    peer.send(8'h11, 1);
    repeat (2) @(posedge sys_clk);
    rdc(`RFS_OFF_FSR, 32'h0);
    rdc(`RFS_OFF_IRQ_ST, 32'h3);
    bus(1'b1, `RFS_OFF_CTRL, 32'h01);
    peer.set_cts(1'b1);
    repeat (4) @(posedge sys_clk);
    rdc(`RFS_OFF_FSR, 32'h0);
    $display("t_tx done");
  endtask : t_tx
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_hw();
    t_sw();
    t_tx();
    stop_test();
  end
endmodule : rx_fill_count_flow_status_test
